// >>> hw/ppc_pkg.sv
// constants shared by the port pin control block
package ppc_pkg;
	// ====================================
	// sizes
	localparam int PPC_PINS = 16;   // pins in one port
	localparam int PPC_NPI  = 4;    // remappable peripheral inputs
	localparam int PPC_NPO  = 4;    // remappable peripheral outputs
	// ====================================
	// per-bit values after reset
	localparam logic PPC_DIR_RST  = 1'h1; // all pins inputs
	localparam logic PPC_ANA_RST  = 1'h1; // pins start analog
	localparam logic PPC_LAT_RST  = 1'h0; // latch cleared
	localparam logic PPC_OD_RST   = 1'h0; // push-pull
	localparam logic PPC_CN_RST   = 1'h0; // notification off
	localparam logic PPC_PU_RST   = 1'h0; // pull-ups off
	localparam logic PPC_SLEW_RST = 1'h1; // reduced slew
	localparam logic PPC_GLB_RST  = 1'h0; // global enable off
	localparam logic PPC_IDL_RST  = 1'h0; // keep running in idle
	localparam logic PPC_LOCK_RST = 1'h0; // mapping unlocked
	localparam int   PPC_SEL_NONE = 0;    // select code for no mapping
endpackage

// >>> hw/ppc_port.sv
// port pin control with change notification and pin remap crossbar
`timescale 1ns/1ps
`default_nettype none
// ====================================
module ppc_port #(
	parameter int W   = ppc_pkg::PPC_PINS,
	parameter int NPI = ppc_pkg::PPC_NPI,
	parameter int NPO = ppc_pkg::PPC_NPO,
	parameter int ISW = $clog2(W + 1),
	parameter int OSW = $clog2(NPO + 1)
) (
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	input  wire logic [W-1:0]             opMask,      // mask for masked operations
	input  wire logic [W-1:0]             wrData,      // full-width write value
	input  wire logic                     portWrEn,    // write port (lands in latch)
	input  wire logic                     latWrEn,     // write latch
	input  wire logic                     latClrEn,    // clear masked latch bits
	input  wire logic                     latSetEn,    // set masked latch bits
	input  wire logic                     latInvEn,    // invert masked latch bits
	input  wire logic                     dirInEn,     // masked bits become inputs
	input  wire logic                     dirOutEn,    // masked bits become outputs
	input  wire logic                     odSetEn,     // masked open-drain enable
	input  wire logic                     odClrEn,     // masked open-drain disable
	input  wire logic                     anaSetEn,    // masked bits become analog
	input  wire logic                     anaClrEn,    // masked bits become digital
	input  wire logic                     slewRedEn,   // select reduced slew
	input  wire logic                     slewStdEn,   // select standard slew
	input  wire logic                     cnEnSetEn,   // masked notification enable
	input  wire logic                     cnEnClrEn,   // masked notification disable
	input  wire logic                     cnPuSetEn,   // masked pull-up enable
	input  wire logic                     cnPuClrEn,   // masked pull-up disable
	input  wire logic                     cnGlbSetEn,  // global notification enable
	input  wire logic                     cnGlbClrEn,  // global notification disable
	input  wire logic                     cnIdlStopEn, // stop notification in sleep/idle
	input  wire logic                     cnIdlRunEn,  // keep notification in sleep/idle
	input  wire logic                     cnFlagClrEn, // clear masked change flags
	input  wire logic                     lowPower,    // device in sleep or idle
	input  wire logic                     mapInWe,     // write an input mapping
	input  wire logic [$clog2(NPI)-1:0]   mapInIdx,    // peripheral input number
	input  wire logic [ISW-1:0]           mapInSel,    // pin number plus one, 0 none
	input  wire logic                     mapOutWe,    // write an output mapping
	input  wire logic [$clog2(W)-1:0]     mapOutIdx,   // pin number
	input  wire logic [OSW-1:0]           mapOutSel,   // peripheral output plus one
	input  wire logic                     lockSetEn,   // lock the mapping
	input  wire logic                     lockClrEn,   // unlock the mapping
	input  wire logic [NPO-1:0]           perOdSetEn,  // per-peripheral open-drain on
	input  wire logic [NPO-1:0]           perOdClrEn,  // per-peripheral open-drain off
	input  wire logic [NPO-1:0]           perOut,      // peripheral output levels
	output logic      [NPI-1:0]           perIn,       // peripheral input levels
	input  wire logic [W-1:0]             padIn,       // pin levels
	output logic      [W-1:0]             padOut,      // pin output levels
	output logic      [W-1:0]             padOeN,      // low while pin driven
	output logic      [W-1:0]             pullUpEn,    // weak pull-up control
	output logic                          slewReduced, // reduced slew select
	output logic      [W-1:0]             portRd,      // pin levels read back
	output logic      [W-1:0]             latRd,       // latch read back
	output logic      [W-1:0]             dirRd,       // direction read back
	output logic      [W-1:0]             cnFlags,     // sticky change flags
	output logic                          cnIrq,       // change interrupt request
	output logic                          mapLocked    // mapping lock state
);
	import ppc_pkg::*;

	// ====================================
	// state
	logic [W-1:0]   padMeta_q, padSync_q;  // pin synchroniser
	logic [W-1:0]   lat_q, lat_d;          // output latch
	logic [W-1:0]   dir_q, od_q, ana_q;    // direction, open-drain, analog
	logic [W-1:0]   cnEn_q, cnPrev_q;      // notification enable, last sample
	logic [W-1:0]   cnFlag_q, cnEvt;       // sticky flags, new events
	logic           cnGlb_q, cnIdl_q;      // global enable, idle stop
	logic           lock_q;                // mapping lock
	logic [NPO-1:0] perOd_q;               // per-peripheral open-drain
	logic [ISW-1:0] inSel_q [NPI];         // input mapping per peripheral
	logic [OSW-1:0] outSel_q [W];          // output mapping per pin
	logic [W-1:0]   outMap, outVal, odEff; // per-pin output selection
	logic [NPI-1:0] perIn_d;               // next peripheral inputs
	logic           cnActive;              // notification running

	// ====================================
	// pin synchroniser, first stage read only by second
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			padMeta_q <= '0;
			padSync_q <= '0;
		end else begin
			padMeta_q <= padIn;
			padSync_q <= padMeta_q;
		end
	end

	// ====================================
	// output latch next value
	always_comb begin
		lat_d = lat_q;
		if (portWrEn || latWrEn) begin
			lat_d = wrData;
		end
		if (latClrEn) begin
			lat_d = lat_d & ~opMask;
		end
		if (latSetEn) begin
			lat_d = lat_d | opMask;
		end
		if (latInvEn) begin
			lat_d = lat_d ^ opMask;
		end
	end

	// latch register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			lat_q <= {W{PPC_LAT_RST}};
		end else begin
			lat_q <= lat_d;
		end
	end

	// ====================================
	// direction, open-drain, analog, slew
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dir_q       <= {W{PPC_DIR_RST}};
			od_q        <= {W{PPC_OD_RST}};
			ana_q       <= {W{PPC_ANA_RST}};
			slewReduced <= PPC_SLEW_RST;
		end else begin
			// masked direction, one is input, input wins
			dir_q       <= (dir_q & ~(opMask & {W{dirOutEn}})) | (opMask & {W{dirInEn}});
			od_q        <= (od_q & ~(opMask & {W{odClrEn}})) | (opMask & {W{odSetEn}});
			// analog select, analog wins
			ana_q       <= (ana_q & ~(opMask & {W{anaClrEn}})) | (opMask & {W{anaSetEn}});
			slewReduced <= slewRedEn || (slewReduced && !slewStdEn);
		end
	end

	// ====================================
	// change notification controls
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cnEn_q   <= {W{PPC_CN_RST}};
			pullUpEn <= {W{PPC_PU_RST}};
			cnGlb_q  <= PPC_GLB_RST;
			cnIdl_q  <= PPC_IDL_RST;
		end else begin
			cnEn_q   <= (cnEn_q & ~(opMask & {W{cnEnClrEn}})) | (opMask & {W{cnEnSetEn}});
			pullUpEn <= (pullUpEn & ~(opMask & {W{cnPuClrEn}})) | (opMask & {W{cnPuSetEn}});
			// global enable, enable wins
			cnGlb_q  <= cnGlbSetEn || (cnGlb_q && !cnGlbClrEn);
			// idle behaviour, stop wins
			cnIdl_q  <= cnIdlStopEn || (cnIdl_q && !cnIdlRunEn);
		end
	end

	assign cnActive = cnGlb_q && !(lowPower && cnIdl_q);
	assign cnEvt = (padSync_q ^ cnPrev_q) & cnEn_q & {W{cnActive}};

	// sticky flags, a new event beats a clear
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cnPrev_q <= '0;
			cnFlag_q <= '0;
			cnIrq    <= 1'h0;
		end else begin
			cnPrev_q <= padSync_q;
			cnFlag_q <= (cnFlag_q & ~(opMask & {W{cnFlagClrEn}})) | cnEvt;
			cnIrq    <= |(cnFlag_q | cnEvt);
		end
	end
	assign cnFlags = cnFlag_q;

	// ====================================
	// crossbar configuration
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int k = 0; k < NPI; k++) begin
				inSel_q[k] <= ISW'(PPC_SEL_NONE);
			end
			for (int i = 0; i < W; i++) begin
				outSel_q[i] <= OSW'(PPC_SEL_NONE);
			end
			lock_q  <= PPC_LOCK_RST;
			perOd_q <= '0;
		end else begin
			if (mapInWe && !lock_q && int'(mapInIdx) < NPI) begin
				inSel_q[mapInIdx] <= mapInSel;
			end
			if (mapOutWe && !lock_q && int'(mapOutIdx) < W) begin
				outSel_q[mapOutIdx] <= mapOutSel;
			end
			lock_q <= lockSetEn || (lock_q && !lockClrEn); // lock wins over unlock
			perOd_q <= (perOd_q | perOdSetEn) & ~(perOdClrEn & ~perOdSetEn);
		end
	end
	assign mapLocked = lock_q;

	// ====================================
	// crossbar routing
	always_comb begin
		for (int i = 0; i < W; i++) begin
			outMap[i] = 1'h0;
			outVal[i] = lat_q[i];
			odEff[i]  = od_q[i];
			// peripheral output on digital pins only
			for (int k = 0; k < NPO; k++) begin
				if (outSel_q[i] == OSW'(k + 1) && !ana_q[i]) begin
					outMap[i] = 1'h1;
					outVal[i] = perOut[k];
					odEff[i]  = od_q[i] | perOd_q[k];
				end
			end
		end
		for (int k = 0; k < NPI; k++) begin
			perIn_d[k] = 1'h0;
			// pin to peripheral input, analog gives zero
			for (int i = 0; i < W; i++) begin
				if (inSel_q[k] == ISW'(i + 1) && !ana_q[i]) begin
					perIn_d[k] = padSync_q[i];
				end
			end
		end
	end

	// ====================================
	// registered pin drive and read-back
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			padOut <= '0;
			padOeN <= '1;
			perIn  <= '0;
			portRd <= '0;
		end else begin
			padOut <= outVal & ~odEff;
			// output direction drives latch even when analog
			padOeN <= ~((outMap | ~dir_q) & (~odEff | ~outVal));
			perIn  <= perIn_d;
			portRd <= padSync_q & ~(ana_q & dir_q);
		end
	end
	assign latRd = lat_q;
	assign dirRd = dir_q;

	// ====================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_rd;
		1 |=> portRd == $past(padSync_q & ~(ana_q & dir_q));
	endproperty
	a_rd: assert property (p_rd) else $error("port read mismatch");

	property p_wr;
		(latWrEn && !latClrEn && !latSetEn && !latInvEn) |=> lat_q == $past(wrData);
	endproperty
	a_wr: assert property (p_wr) else $error("latch write lost");

	property p_clr;
		(latClrEn && !latWrEn && !portWrEn && !latSetEn && !latInvEn)
			|=> lat_q == ($past(lat_q) & ~$past(opMask));
	endproperty
	a_clr: assert property (p_clr) else $error("masked clear wrong");

	property p_set;
		(latSetEn && !latWrEn && !portWrEn && !latClrEn && !latInvEn)
			|=> lat_q == ($past(lat_q) | $past(opMask));
	endproperty
	a_set: assert property (p_set) else $error("masked set wrong");

	property p_inv;
		(latInvEn && !latWrEn && !portWrEn && !latClrEn && !latSetEn)
			|=> lat_q == ($past(lat_q) ^ $past(opMask));
	endproperty
	a_inv: assert property (p_inv) else $error("masked invert wrong");

	property p_cngate;
		1 |=> (cnFlag_q & ~$past(cnFlag_q) & ~($past(cnEn_q) & {W{$past(cnActive)}})) == '0;
	endproperty
	a_cngate: assert property (p_cngate) else $error("flag set while disabled");

	// packed copies of both mapping tables, so the lock check sees every entry
	logic [NPI*ISW-1:0] inSelFlat;   // all input selections
	logic [W*OSW-1:0]   outSelFlat;  // all output selections
	always_comb begin
		for (int k = 0; k < NPI; k++) begin
			inSelFlat[k*ISW +: ISW] = inSel_q[k];
		end
		for (int i = 0; i < W; i++) begin
			outSelFlat[i*OSW +: OSW] = outSel_q[i];
		end
	end

	property p_lock;
		lock_q && (mapInWe || mapOutWe) |=> $stable(inSelFlat) && $stable(outSelFlat);
	endproperty
	a_lock: assert property (p_lock) else $error("mapping changed while locked");

	property p_ana;
		1 |=> (~padOeN & $past(ana_q & dir_q)) == '0;
	endproperty
	a_ana: assert property (p_ana) else $error("analog input pin driven");

	property p_irq;
		(|cnEvt) |=> cnIrq && (cnFlag_q & $past(cnEvt)) == $past(cnEvt);
	endproperty
	a_irq: assert property (p_irq) else $error("change event lost");

	property p_rst;
		@(posedge core_clk) !rstn |=> dir_q == '1 && perIn == '0 && padOeN == '1;
	endproperty
	a_rst: assert property (disable iff (1'b0) p_rst) else $error("bad reset state");

	c_evt:  cover property (|cnEvt ##1 cnIrq);
	c_lock: cover property (lock_q && mapInWe);
	c_map:  cover property (|outMap && !(&padOeN));
	c_perin: cover property (|perIn);
endmodule
`default_nettype wire

// >>> testbench/ppc_port_tb.sv
// self-checking bench for the port pin control block
`timescale 1ns/1ps
`default_nettype none
module ppc_port_tb;
	import ppc_pkg::*;
	// ====================================
	// stimulus and observed signals
	logic        core_clk  = 1'h0;  // 40 MHz core clock
	logic        rstn      = 1'h0;  // sync reset, active low
	logic [25:0] stb       = '0;    // one bit for each single-cycle strobe
	logic [15:0] opMask    = '0;    // mask for masked strobes
	logic [15:0] wrData    = '0;    // full-width write value
	logic        lowPower  = 1'h0;  // sleep or idle level
	logic [1:0]  mapInIdx  = '0;    // peripheral input number
	logic [4:0]  mapInSel  = '0;    // pin plus one
	logic [3:0]  mapOutIdx = '0;    // pin number
	logic [2:0]  mapOutSel = '0;    // peripheral output plus one
	logic [3:0]  perOdSet  = '0;    // per-output open-drain on
	logic [3:0]  perOdClr  = '0;    // per-output open-drain off
	logic [3:0]  perOut    = '0;    // peripheral output levels
	logic [15:0] padIn     = '0;    // pin levels seen by the block
	logic [3:0]  perIn;             // routed peripheral inputs
	logic [15:0] padOut, padOeN, pullUpEn, portRd, latRd, dirRd, cnFlags;
	logic        slewReduced, cnIrq, mapLocked;
	int          nErrors   = 0;     // mismatches seen
	int          nTests    = 0;     // comparisons made
	// ====================================
	// clock
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	// ====================================
	// device under test, strobes taken from the stb vector
	ppc_port dut_u (.core_clk(core_clk), .rstn(rstn), .opMask(opMask), .wrData(wrData),
		.portWrEn(stb[0]), .latWrEn(stb[1]), .latClrEn(stb[2]), .latSetEn(stb[3]), .latInvEn(stb[4]),
		.dirInEn(stb[5]), .dirOutEn(stb[6]), .odSetEn(stb[7]), .odClrEn(stb[8]), .anaSetEn(stb[9]),
		.anaClrEn(stb[10]), .slewRedEn(stb[11]), .slewStdEn(stb[12]), .cnEnSetEn(stb[13]),
		.cnEnClrEn(stb[14]), .cnPuSetEn(stb[15]), .cnPuClrEn(stb[16]), .cnGlbSetEn(stb[17]),
		.cnGlbClrEn(stb[18]), .cnIdlStopEn(stb[19]), .cnIdlRunEn(stb[20]), .cnFlagClrEn(stb[21]),
		.lowPower(lowPower), .mapInWe(stb[22]), .mapInIdx(mapInIdx), .mapInSel(mapInSel),
		.mapOutWe(stb[23]), .mapOutIdx(mapOutIdx), .mapOutSel(mapOutSel), .lockSetEn(stb[24]),
		.lockClrEn(stb[25]), .perOdSetEn(perOdSet), .perOdClrEn(perOdClr), .perOut(perOut),
		.perIn(perIn), .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .pullUpEn(pullUpEn),
		.slewReduced(slewReduced), .portRd(portRd), .latRd(latRd), .dirRd(dirRd), .cnFlags(cnFlags),
		.cnIrq(cnIrq), .mapLocked(mapLocked));
	// ====================================
	// helpers, all entered at a falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// one strobe cycle, then a quiet cycle so pin outputs settle too
	task automatic st(input int k, input logic [15:0] m, input logic [15:0] d);
		stb[k] = 1'h1;
		opMask = m;
		wrData = d;
		tick(1);
		stb = '0;
		tick(1);
	endtask
	// compare one value of up to port width
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// flip pin 12 and let it pass synchroniser and detector
	task automatic flip();
		padIn[12] = ~padIn[12];
		tick(5);
	endtask
	// bounded wait for the change request
	task automatic wait_irq();
		for (int i = 0; i < 8 && cnIrq !== 1'h1; i++) begin
			tick(1);
		end
		if (cnIrq !== 1'h1) begin
			nErrors++;
			report_and_stop();
		end
	endtask
	task automatic report_and_stop();
		$display("counts: tests=%0d errors=%0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ====================================
	// watchdog against a hang
	initial begin
		#2ms;
		nErrors++;
		report_and_stop();
	end
	// ====================================
	// main sequence
	initial begin
		tick(4);
		rstn = 1'h1;
		chk(dirRd, 16'hffff);
		chk(latRd, 16'h0000);
		chk(padOeN, 16'hffff);
		chk({12'h000, perIn}, 16'h0000);
		chk(portRd, 16'h0000);
		chk({13'h0000, cnIrq, mapLocked, slewReduced}, 16'h0001);
		$display("test reset done");
		// latch write, clear, set, invert, port write
		st(1, 16'h0000, 16'h1234);
		chk(latRd, 16'h1234);
		st(2, 16'h00ff, 16'h0000);
		chk(latRd, 16'h1200);
		st(3, 16'h00ff, 16'h0000);
		chk(latRd, 16'h12ff);
		st(4, 16'h0f0f, 16'h0000);
		chk(latRd, 16'h1df0);
		st(0, 16'h0000, 16'ha5c3);
		chk(latRd, 16'ha5c3);
		$display("test latch done");
		// low byte outputs while still analog, pad level follows the latch on every pin
		st(6, 16'h00ff, 16'h0000);
		chk(dirRd, 16'hff00);
		chk(padOut, 16'ha5c3);
		chk(padOeN, 16'hff00);
		padIn = 16'hf05a;
		tick(4);
		chk(portRd, 16'h005a);
		st(10, 16'hffff, 16'h0000);
		tick(3);
		chk(portRd, 16'hf05a);
		// upper nibble of the low byte back to input, then output again
		st(5, 16'h00f0, 16'h0000);
		chk(dirRd, 16'hfff0);
		chk(padOeN, 16'hfff0);
		st(6, 16'h00f0, 16'h0000);
		chk(dirRd, 16'hff00);
		$display("test direction and read done");
		// port open-drain on low nibble, latch nibble is 3
		st(7, 16'h000f, 16'h0000);
		chk(padOut, 16'ha5c0);
		chk(padOeN, 16'hff03);
		st(8, 16'h000f, 16'h0000);
		chk(padOeN, 16'hff00);
		st(12, 16'h0000, 16'h0000);
		chk({15'h0000, slewReduced}, 16'h0000);
		st(11, 16'h0000, 16'h0000);
		chk({15'h0000, slewReduced}, 16'h0001);
		// pull-ups on input pins 12 and 13, then off again on 12, outputs keep theirs off
		st(15, 16'h3000, 16'h0000);
		st(16, 16'h1000, 16'h0000);
		chk(pullUpEn, 16'h2000);
		$display("test drive options done");
		// change notification on pin 12
		st(13, 16'h1000, 16'h0000);
		st(17, 16'h0000, 16'h0000);
		flip();
		wait_irq();
		chk(cnFlags, 16'h1000);
		st(21, 16'h1000, 16'h0000);
		chk({cnIrq, cnFlags[14:0]}, 16'h0000);
		st(18, 16'h0000, 16'h0000);
		flip();
		chk(cnFlags, 16'h0000);
		st(17, 16'h0000, 16'h0000);
		st(19, 16'h0000, 16'h0000);
		lowPower = 1'h1;
		flip();
		chk(cnFlags, 16'h0000);
		st(20, 16'h0000, 16'h0000);
		flip();
		chk(cnFlags, 16'h1000);
		lowPower = 1'h0;
		st(21, 16'hffff, 16'h0000);
		st(14, 16'h1000, 16'h0000);
		flip();
		chk(cnFlags, 16'h0000);
		$display("test change notification done");
		// remap: peripheral input 1 from pin 13, pin 9 from output 1
		mapInIdx = 2'h1;
		mapInSel = 5'h0e;
		st(22, 16'h0000, 16'h0000);
		chk({12'h000, perIn}, 16'h0002);
		st(9, 16'h2000, 16'h0000);
		chk({12'h000, perIn}, 16'h0000);
		st(10, 16'h2000, 16'h0000);
		chk({12'h000, perIn}, 16'h0002);
		mapOutIdx = 4'h9;
		mapOutSel = 3'h2;
		perOut = 4'h2;
		st(23, 16'h0000, 16'h0000);
		chk(padOut, 16'ha7c3);
		chk(padOeN, 16'hfd00);
		perOdSet = 4'h2;
		tick(1);
		perOdSet = 4'h0;
		tick(1);
		chk(padOut, 16'ha5c3);
		chk(padOeN, 16'hff00);
		perOdClr = 4'h2;
		tick(1);
		perOdClr = 4'h0;
		tick(1);
		chk(padOut, 16'ha7c3);
		chk(padOeN, 16'hfd00);
		// lock refuses a new input mapping
		st(24, 16'h0000, 16'h0000);
		chk({15'h0000, mapLocked}, 16'h0001);
		mapInSel = 5'h00;
		st(22, 16'h0000, 16'h0000);
		chk({12'h000, perIn}, 16'h0002);
		st(25, 16'h0000, 16'h0000);
		st(22, 16'h0000, 16'h0000);
		chk({12'h000, perIn}, 16'h0000);
		$display("test remap done");
		report_and_stop();
	end
endmodule
`default_nettype wire
